// ### acs_consts.svh
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
// clock rates, converter clock derived by division
`define ACS_SYS_MHZ 100
`define ACS_CONV_MHZ 20
`define ACS_DIV_RST ((`ACS_SYS_MHZ / `ACS_CONV_MHZ) - 1)
// conversion length in converter clocks
`define ACS_CONV_CYCLES 14
`define ACS_CONV_LAST 4'(`ACS_CONV_CYCLES - 1)
// filter coefficient scale is 1/4096
`define ACS_ALPHA_SHIFT 12
`define ACS_ALPHA_BYPASS 8'hff
`define ACS_ALPHA_HOLD 8'h00
`define ACS_ALPHA_RST 8'hff
`define ACS_UPPER_RST 16'hffc0
`define ACS_LOWER_RST 16'h0000
`define ACS_SLOTSEL_RST 8'he4
`define ACS_SLOTS_ALL 2'h0
`define ACS_PAD 6'h00
// register map: region in adr[7:6], word in adr[5:2]
`define ACS_RGN_MISC 2'h0
`define ACS_RGN_ALPHA 2'h1
`define ACS_RGN_LIMIT 2'h2
`define ACS_RGN_RESULT 2'h3
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_SLOTS 8'h04
`define ACS_OFF_FLAGS 8'h08
`define ACS_OFF_FCLR 8'h0c
// flag vector bit positions
`define ACS_FLG_HI0 0
`define ACS_FLG_LO0 4
`define ACS_FLG_HI1 8
`define ACS_FLG_LO1 12
`define ACS_FLG_OR2 16
// debug selector codes
`define ACS_DBG_CLK0 4'h5
`define ACS_DBG_CLK1 4'h6
`define ACS_DBG_CLK2 4'h7
`define ACS_DBG_BUSY0 4'h8
`define ACS_DBG_BUSY1 4'h9
`define ACS_DBG_BUSY2 4'ha
`endif

// ### acs_pkg.sv
package acs_pkg;
	// control word layout, top field is bit 31
	typedef struct packed {
		logic [5:0] rsv_hi;       // reads zero
		logic [2:0] conv_en;      // converter run enables
		logic [7:0] clk_div;      // converter clock period minus one
		logic [3:0] dbg_sel;      // debug signal selector
		logic grid_ref;           // grid input reference select
		logic [1:0] grid_filt;    // grid input analog filter select
		logic [1:0][1:0] slots;   // slot count, [1] converter one
		logic [2:0] rsv_lo;       // reads zero
		logic rd_req;             // result read request
	} acs_ctrl_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} acs_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} acs_wb_rsp_t;
	// toward the analog cores
	typedef struct packed {
		logic [2:0] busy;
		logic conv_clk;
		logic [1:0] sel0;
		logic [1:0] sel1;
		logic [1:0] grid_filt;
		logic grid_ref;
	} acs_core_out_t;
	// from the analog cores
	typedef struct packed {
		logic [2:0][9:0] data;
		logic [2:0] chan2;
	} acs_core_in_t;
	typedef enum logic [1:0] {F_IDLE, F_READ, F_WRITE} acs_fstage_t;
	typedef struct packed {
		acs_ctrl_t ctrl;
		logic [1:0][7:0] slotsel;
		logic [15:0][7:0] alpha;
		logic [15:0][15:0] upper;
		logic [15:0][15:0] lower;
		logic [23:0] flags;
		logic [7:0] divcnt;
		logic [2:0] busy;
		logic [2:0][3:0] cnt;
		logic [1:0][1:0] slot;
		logic [2:0] pend;
		logic [2:0][9:0] val;
		logic [2:0][3:0] ch;
		acs_fstage_t fst;
		logic [3:0] fch;
		logic [9:0] fval;
		logic bph;
		acs_wb_rsp_t rsp;
		acs_core_out_t core;
		logic dbg;
		logic [23:0] events;
	} acs_main_t;
	typedef struct packed {
		logic [15:0][23:0] mem;
		logic [23:0] ra;
		logic [23:0] rb;
	} acs_mem_t;
endpackage

// ### acs_chan_mem.sv
`timescale 1ns/1ps
// ----------------------------------------
// filter state store, one word per channel
// ----------------------------------------
module acs_chan_mem (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [3:0] waddr_i,
	input wire logic [23:0] wdata_i,
	input wire logic [3:0] raddr_a_i,
	output logic [23:0] rdata_a_o,
	input wire logic [3:0] raddr_b_i,
	output logic [23:0] rdata_b_o
);
	import acs_pkg::*;
	acs_mem_t st; // words and both read registers
	acs_mem_t next_st; // next value

	// two registered read ports, one write port
	always_comb begin
		next_st = st;
		if (rst_i) begin
			next_st = '0; // results read zero until first sample
		end else begin
			next_st.ra = st.mem[raddr_a_i];
			next_st.rb = st.mem[raddr_b_i];
			if (we_i) begin
				next_st.mem[waddr_i] = wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign rdata_a_o = st.ra;
	assign rdata_b_o = st.rb;
endmodule

// ### acs_monitor.sv
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input acs_pkg::acs_wb_req_t wb_req_i,
	output acs_pkg::acs_wb_rsp_t wb_rsp_o,
	input acs_pkg::acs_core_in_t core_i,
	output acs_pkg::acs_core_out_t core_o,
	output logic dbg_o,
	output logic [23:0] events_o
);
	import acs_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// input picked by the selector of a slot
	function automatic logic [1:0] slot_input(input logic [7:0] sel, input logic [1:0] slot);
		return sel[slot*2 +: 2];
	endfunction

	// round-robin step; count 00 means four slots
	function automatic logic [1:0] slot_step(input logic [1:0] slot, input logic [1:0] count);
		logic [2:0] n;
		n = (count == `ACS_SLOTS_ALL) ? 3'h4 : {1'b0, count};
		return (({1'b0, slot} + 3'h1) >= n) ? 2'h0 : 2'(slot + 2'h1);
	endfunction

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = wdat[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// state and working signals
	// ----------------------------------------
	acs_main_t st; // all registered state
	acs_main_t next_st; // next value
	logic tick; // converter clock enable
	logic [23:0] mem_ra; // filter state of channel in work
	logic [23:0] mem_rb; // filter state for bus read
	logic mem_we; // filter state write
	logic [15:0] s16; // unfiltered result, left aligned
	logic [23:0] x24; // same with fraction byte
	logic signed [24:0] diff; // input minus filter state
	logic signed [33:0] prod; // diff times alpha
	logic [23:0] filt; // new filter state
	logic hi; // above upper limit
	logic lo; // below lower limit
	logic [23:0] flag_set; // flags raised this cycle
	logic [2:0] done; // conversion finished this cycle
	logic [1:0] pick; // converter served by the filter
	logic [3:0] ai; // channel index of bus word
	logic [31:0] rdat; // bus read value
	logic [31:0] wd; // merged bus write value
	logic bus_go; // bus access completes this cycle
	logic fclr_wr; // flag clear write completes
	logic ctrl_wr; // control write completes

	// filter state store, shared by filter and bus
	acs_chan_mem u_mem (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(mem_we),
		.waddr_i(st.fch),
		.wdata_i(filt),
		.raddr_a_i(st.fch),
		.rdata_a_o(mem_ra),
		.raddr_b_i(wb_req_i.adr[5:2]),
		.rdata_b_o(mem_rb)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		done = '0;
		flag_set = '0;
		pick = 2'h0;
		tick = (st.divcnt == 8'h00);
		mem_we = (st.fst == F_WRITE);
		// filter datapath: y += alpha * (x - y) / 4096
		s16 = {st.fval, `ACS_PAD};
		x24 = {s16, 8'h00};
		diff = $signed({1'b0, x24}) - $signed({1'b0, mem_ra});
		prod = diff * $signed({1'b0, st.alpha[st.fch]});
		if (st.alpha[st.fch] == `ACS_ALPHA_BYPASS) begin
			filt = x24;
		end else begin
			filt = 24'(mem_ra + 24'(prod >>> `ACS_ALPHA_SHIFT)); // alpha 0 adds nothing
		end
		// comparators see the raw sample, not the filter
		hi = (s16 > st.upper[st.fch]);
		lo = (s16 < st.lower[st.fch]);
		if (st.fst == F_WRITE) begin
			case (st.fch[3:2])
				2'h0: begin
					flag_set[`ACS_FLG_HI0 + st.fch[1:0]] = hi;
					flag_set[`ACS_FLG_LO0 + st.fch[1:0]] = lo;
				end
				2'h1: begin
					flag_set[`ACS_FLG_HI1 + st.fch[1:0]] = hi;
					flag_set[`ACS_FLG_LO1 + st.fch[1:0]] = lo;
				end
				default: begin
					flag_set[`ACS_FLG_OR2 + st.fch[2:0]] = hi | lo;
				end
			endcase
		end
		// lowest pending converter wins the filter
		for (int k = 2; k >= 0; k--) begin
			if (st.pend[k]) begin
				pick = 2'(k);
			end
		end
		// bus decode
		ai = wb_req_i.adr[5:2];
		case (wb_req_i.adr[7:6])
			`ACS_RGN_MISC: begin
				case (wb_req_i.adr)
					`ACS_OFF_CTRL: rdat = st.ctrl;
					`ACS_OFF_SLOTS: rdat = {16'h0000, st.slotsel};
					`ACS_OFF_FLAGS: rdat = {8'h00, st.flags};
					default: rdat = 32'h0000_0000; // clear word and holes read zero
				endcase
			end
			`ACS_RGN_ALPHA: rdat = {24'h00_0000, st.alpha[ai]};
			`ACS_RGN_LIMIT: rdat = {st.upper[ai], st.lower[ai]};
			default: rdat = {16'h0000, mem_rb[23:8]};
		endcase
		wd = byte_merge(rdat, wb_req_i.dat, wb_req_i.sel);
		bus_go = st.bph;
		fclr_wr = bus_go && wb_req_i.we && (wb_req_i.adr == `ACS_OFF_FCLR);
		ctrl_wr = bus_go && wb_req_i.we && (wb_req_i.adr == `ACS_OFF_CTRL);

		if (rst_i) begin
			next_st = '0;
			next_st.ctrl.clk_div = 8'(`ACS_DIV_RST);
			next_st.divcnt = 8'(`ACS_DIV_RST);
			next_st.slotsel = {2{`ACS_SLOTSEL_RST}}; // slot n picks input n
			next_st.alpha = {16{`ACS_ALPHA_RST}};
			next_st.upper = {16{`ACS_UPPER_RST}};
			next_st.lower = {16{`ACS_LOWER_RST}};
			next_st.fst = F_IDLE;
			next_st.core.sel1 = 2'h0; // grid filter, count fields and slots start at 00
		end else begin
			// converter clock divider, period clk_div+1
			next_st.divcnt = tick ? st.ctrl.clk_div : 8'(st.divcnt - 8'h01);

			// filter pipeline: pick, read state, write state
			case (st.fst)
				F_IDLE: begin
					if (|st.pend) begin
						next_st.fst = F_READ;
						next_st.fch = st.ch[pick];
						next_st.fval = st.val[pick];
						next_st.pend[pick] = 1'b0;
					end
				end
				F_READ: begin
					next_st.fst = F_WRITE; // state word arrives next cycle
				end
				F_WRITE: begin
					next_st.fst = F_IDLE;
					next_st.ctrl.rd_req = 1'b0; // data ready
				end
				default: begin
					next_st.fst = F_IDLE;
				end
			endcase

			// conversion engines, back to back while enabled
			for (int k = 0; k < 3; k++) begin
				if (!st.ctrl.conv_en[k]) begin
					next_st.busy[k] = 1'b0;
					next_st.cnt[k] = 4'h0;
				end else if (tick) begin
					if (!st.busy[k]) begin
						next_st.busy[k] = 1'b1;
						next_st.cnt[k] = 4'h0;
					end else if (st.cnt[k] == `ACS_CONV_LAST) begin
						done[k] = 1'b1;
						next_st.cnt[k] = 4'h0;
						next_st.pend[k] = 1'b1; // set after the pick, so it is never lost
						next_st.val[k] = core_i.data[k];
						case (k)
							0: next_st.ch[k] = {2'h0, slot_input(st.slotsel[0], st.slot[0])};
							1: next_st.ch[k] = {2'h1, slot_input(st.slotsel[1], st.slot[1])};
							default: next_st.ch[k] = {1'h1, core_i.chan2};
						endcase
					end else begin
						next_st.cnt[k] = 4'(st.cnt[k] + 4'h1);
					end
				end
			end
			// slot sequencing; n slots each get 1/n of the rate
			for (int k = 0; k < 2; k++) begin
				if (done[k]) begin
					next_st.slot[k] = slot_step(st.slot[k], st.ctrl.slots[k]);
				end
			end

			// bus slave: take, wait a cycle for memory, answer
			next_st.rsp.ack = 1'b0;
			if (!st.bph && !st.rsp.ack && wb_req_i.cyc && wb_req_i.stb) begin
				next_st.bph = 1'b1;
			end else if (bus_go) begin
				next_st.bph = 1'b0;
				next_st.rsp.ack = 1'b1;
				next_st.rsp.dat = rdat;
				if (wb_req_i.we) begin
					case (wb_req_i.adr[7:6])
						`ACS_RGN_MISC: begin
							case (wb_req_i.adr)
								`ACS_OFF_CTRL: begin
									next_st.ctrl = acs_ctrl_t'(wd); // software set beats clear
									next_st.ctrl.rsv_hi = '0;
									next_st.ctrl.rsv_lo = '0;
								end
								`ACS_OFF_SLOTS: next_st.slotsel = wd[15:0];
								`ACS_OFF_FCLR: next_st.flags = st.flags & ~wd[23:0];
								default: next_st.flags = next_st.flags; // read-only or hole
							endcase
						end
						`ACS_RGN_ALPHA: next_st.alpha[ai] = wd[7:0];
						`ACS_RGN_LIMIT: begin
							next_st.upper[ai] = wd[31:16];
							next_st.lower[ai] = wd[15:0];
						end
						default: next_st.flags = next_st.flags; // results ignore writes
					endcase
				end
			end
			// a breach in the clear cycle still sets the flag
			next_st.flags = next_st.flags | flag_set;

			// registered outputs
			next_st.events = st.flags;
			next_st.core.busy = next_st.busy;
			next_st.core.conv_clk = (st.divcnt > {1'b0, st.ctrl.clk_div[7:1]});
			next_st.core.sel0 = slot_input(next_st.slotsel[0], next_st.slot[0]);
			next_st.core.sel1 = slot_input(next_st.slotsel[1], next_st.slot[1]);
			next_st.core.grid_filt = st.ctrl.grid_filt;
			next_st.core.grid_ref = st.ctrl.grid_ref;
			case (st.ctrl.dbg_sel)
				`ACS_DBG_CLK0, `ACS_DBG_CLK1, `ACS_DBG_CLK2: next_st.dbg = st.core.conv_clk;
				`ACS_DBG_BUSY0: next_st.dbg = st.busy[0];
				`ACS_DBG_BUSY1: next_st.dbg = st.busy[1];
				`ACS_DBG_BUSY2: next_st.dbg = st.busy[2];
				default: next_st.dbg = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign wb_rsp_o = st.rsp;
	assign core_o = st.core;
	assign dbg_o = st.dbg;
	assign events_o = st.events;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_bypass;
		(st.fst == F_WRITE && st.alpha[st.fch] == `ACS_ALPHA_BYPASS) |=> ##1 (st.fch != $past(st.fch, 2))
			|| (mem_ra == {$past(st.fval, 2), `ACS_PAD, 8'h00}) || (st.fst != F_IDLE);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass alpha did not pass sample");

	property p_hold;
		(st.fst == F_WRITE && st.alpha[st.fch] == `ACS_ALPHA_HOLD) |-> (filt == mem_ra);
	endproperty
	a_hold: assert property (p_hold) else $error("zero alpha moved filter state");

	property p_conv_end;
		(tick && st.ctrl.conv_en[0] && st.busy[0] && st.cnt[0] == `ACS_CONV_LAST)
			|=> (st.pend[0] && st.cnt[0] == 4'h0);
	endproperty
	a_conv_end: assert property (p_conv_end) else $error("conversion end not captured");

	property p_cnt_bound;
		st.busy[1] |-> (st.cnt[1] <= `ACS_CONV_LAST);
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("conversion count overran");

	property p_slot_wrap;
		(tick && st.ctrl.conv_en[0] && st.busy[0] && st.cnt[0] == `ACS_CONV_LAST
			&& st.ctrl.slots[0] == 2'h2 && st.slot[0] == 2'h1) |=> (st.slot[0] == 2'h0);
	endproperty
	a_slot_wrap: assert property (p_slot_wrap) else $error("slot did not wrap");

	property p_sticky;
		(st.flags != '0 && !fclr_wr) |=> ((st.flags & $past(st.flags)) == $past(st.flags));
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

	property p_event;
		(|flag_set) |=> ((st.flags & $past(flag_set)) == $past(flag_set))
			##1 ((events_o & $past(flag_set, 2)) == $past(flag_set, 2));
	endproperty
	a_event: assert property (p_event) else $error("breach not exported");

	property p_or2;
		(st.fst == F_WRITE && st.fch[3] && (hi || lo)) |=> st.flags[`ACS_FLG_OR2 + st.fch[2:0]];
	endproperty
	a_or2: assert property (p_or2) else $error("third converter flag not set");

	property p_rdreq;
		(st.fst == F_WRITE && !ctrl_wr) |=> !st.ctrl.rd_req;
	endproperty
	a_rdreq: assert property (p_rdreq) else $error("read request not cleared");

	property p_dbg;
		(st.ctrl.dbg_sel == `ACS_DBG_BUSY0) |=> (dbg_o == $past(st.busy[0]));
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug pin not busy");

	property p_ack;
		wb_rsp_o.ack |=> !wb_rsp_o.ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack longer than one cycle");
endmodule

// ### acs_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// analog core stand-in for the three converters
// ----------------------------------------
module acs_core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input acs_pkg::acs_core_out_t core_i,
	input wire logic [9:0] bias_i,
	output acs_pkg::acs_core_in_t core_o
);
	import acs_pkg::*;
	logic [2:0] chan_q; // channel of converter two, rotates while busy

	// ----------------------------------------
	// result levels
	// ----------------------------------------
	// level depends on the selected input, so a wrong pick shows in the value
	always_comb begin
		core_o.data[0] = {core_i.sel0, 8'h00} + bias_i;
		core_o.data[1] = {core_i.sel1, 8'h00} + bias_i;
		core_o.data[2] = {chan_q, 7'h00} + bias_i;
		core_o.chan2 = chan_q;
		// idle converter: lines show the inverse, never a stale value
		for (int k = 0; k < 3; k++) begin
			if (!core_i.busy[k]) begin
				core_o.data[k] = ~core_o.data[k];
			end
		end
	end

	// channel rotation, only while converter two runs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chan_q <= 3'h0;
		end else if (core_i.busy[2]) begin
			chan_q <= chan_q + 3'h1;
		end
	end
endmodule

// ### acs_monitor_test.sv
`timescale 1ns/1ps
`include "acs_consts.svh"
// ----------------------------------------
// register-level bench for the monitor
// ----------------------------------------
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("BAD %0t line %0d got %h exp %h", $time, `__LINE__, g, e); end end
module acs_monitor_test;
	import acs_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	acs_wb_req_t wb_req = '0; // bus master side
	acs_wb_rsp_t wb_rsp;
	acs_core_in_t core_in;
	acs_core_out_t core_out;
	logic dbg;
	logic [23:0] events;
	logic [9:0] bias = 10'h005; // offset added to every core level
	logic [31:0] rd;
	int err_total = 0;
	int checks_done = 0;

	always #5 clk_i = ~clk_i;

	acs_monitor DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
		.core_i(core_in), .core_o(core_out), .dbg_o(dbg), .events_o(events));
	acs_core_model MODEL (.clk_i(clk_i), .rst_i(rst_i), .core_i(core_out), .bias_i(bias), .core_o(core_in));

	// ----------------------------------------
	// closing report
	// ----------------------------------------
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// classic single cycle, held until ack is sampled
	// ----------------------------------------
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] q);
		int n;
		n = 0;
		q = '0;
		@(posedge clk_i);
		wb_req.cyc <= 1'b1;
		wb_req.stb <= 1'b1;
		wb_req.we <= we;
		wb_req.adr <= adr;
		wb_req.sel <= 4'hf;
		wb_req.dat <= wd;
		// bounded wait; a hang ends the run
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		q = wb_rsp.dat;
		wb_req.cyc <= 1'b0;
		wb_req.stb <= 1'b0;
		if (n >= 20) begin
			err_total++;
			$display("BAD %0t bus timeout at %h", $time, adr);
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		bus(1'b1, adr, d, rd);
	endtask

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] e);
		bus(1'b0, adr, 32'h0, rd);
		`CHK(rd, e)
	endtask

	// results arrive at converter pace, so read until they settle
	task automatic poll(input logic [7:0] adr, input logic [31:0] e);
		for (int i = 0; i < 60; i++) begin
			bus(1'b0, adr, 32'h0, rd);
			if (rd === e) begin
				break;
			end
		end
		`CHK(rd, e)
	endtask

	// control word: clk_div 0, slots conv0 10b conv1 01b, grid filter 11b, grid ref 1
	function automatic logic [31:0] ctrl(input logic [2:0] en, input logic [3:0] dsel);
		return 32'h0000_0760 | {6'h0, en, 8'h00, dsel, 11'h000};
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset map
		rdchk(8'h00, 32'h0002_0000);
		rdchk(8'h04, 32'h0000_e4e4);
		for (int ch = 0; ch < 16; ch++) begin
			rdchk(8'(64 + 4 * ch), 32'h0000_00ff);
			rdchk(8'(128 + 4 * ch), 32'hffc0_0000);
		end
		rdchk(8'h08, 32'h0);
		rdchk(8'h10, 32'h0);
		`CHK(core_out.grid_filt, 2'h0)
		// limits: ch1 low, ch3 high, ch6 low
		wr(8'h84, 32'hffc0_5000);
		wr(8'h8c, 32'hc000_0000);
		wr(8'h98, 32'hffc0_ffff);
		// conv0 slots 3,1; conv1 slot0 on grid input a buffered
		wr(8'h04, 32'h0000_e6e7);
		wr(8'h00, ctrl(3'h3, 4'h0));
		// pins follow the control word one register stage after the write lands
		@(posedge clk_i);
		`CHK(core_out.grid_filt, 2'h3)
		`CHK(core_out.grid_ref, 1'b1)
		poll(8'hcc, 32'h0000_c140);
		poll(8'hc4, 32'h0000_4140);
		poll(8'hd8, 32'h0000_8140);
		rdchk(8'hc0, 32'h0);
		rdchk(8'hc8, 32'h0);
		rdchk(8'hd0, 32'h0);
		`CHK(core_out.busy, 3'h3)
		// read request, cleared by the block once data is ready
		wr(8'h00, ctrl(3'h3, 4'h0) | 32'h1);
		poll(8'h00, ctrl(3'h3, 4'h0));
		poll(8'h08, 32'h0000_4028);
		`CHK(events, 24'h00_4028)
		// busy export codes: conv0 and conv1 run, conv2 idle
		for (int c = 8; c <= 10; c++) begin
			wr(8'h00, ctrl(3'h3, 4'(c)));
			rdchk(8'h10, 32'h0);
			`CHK(dbg, c != 10)
		end
		wr(8'hcc, 32'h0000_1234);
		rdchk(8'hcc, 32'h0000_c140);
		// stop, flags stay until cleared
		wr(8'h00, ctrl(3'h0, 4'h0));
		rdchk(8'h08, 32'h0000_4028);
		`CHK(core_out.busy, 3'h0)
		wr(8'h0c, 32'h0000_4028);
		rdchk(8'h08, 32'h0);
		`CHK(events, 24'h0)
		// alpha 0 freezes ch3 while bypassed channels follow the new level;
		// converter two joins, its ch9 sample sits under a lower limit of ffff
		wr(8'h4c, 32'h0);
		wr(8'ha4, 32'hffc0_ffff);
		bias <= 10'h010;
		wr(8'h00, ctrl(3'h7, 4'h0));
		poll(8'hc4, 32'h0000_4400);
		poll(8'hd8, 32'h0000_8400);
		rdchk(8'hcc, 32'h0000_c140);
		poll(8'he4, 32'h0000_2400);
		poll(8'h08, 32'h0002_4028);
		summarize();
	end
endmodule
